// [logic/bcelc_channel.sv]
// single channel: enable, loop routing, clearing, queue pointers and bus driver control
`timescale 1ns/1ps
module bcelc_channel
	import bcelc_pkg::*;
(
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      rst,
	// control from the register side
	input  wire logic                      enableSet,
	input  wire logic                      enableClear,
	input  wire logic                      loopRequest,
	// transfer side
	input  wire logic                      txStart,
	input  wire logic                      txBit,
	input  wire logic                      txDone,
	input  wire logic                      queuePush,
	input  wire logic                      queuePop,
	input  wire logic [BCELC_STATUS_W-1:0] statusSet,
	input  wire logic [BCELC_DATA_W-1:0]   bufferWrite,
	input  wire logic                      bufferLoad,
	// bus pins, receive pin already synchronised at the top
	input  wire logic                      busRxSync,
	output logic                           busTxOut,
	output logic                           busTxOe,
	// observed state
	output logic                           channelEnable,
	output logic                           loopActive,
	output logic                           transferBusy,
	output logic                           rxBit,
	output logic                           clearPulse,
	output logic [BCELC_STATUS_W-1:0]      channelStatus,
	output logic [BCELC_DATA_W-1:0]        bufferData,
	output logic [BCELC_PTR_W-1:0]         txPtr,
	output logic [BCELC_PTR_W-1:0]         rxPtr
);

	typedef struct packed {
		bcelc_mode_e                 mode;
		logic                        loop;
		logic                        busy;
		logic                        txLevel;
		logic                        rxLevel;
		logic                        clr;
		logic [BCELC_STATUS_W-1:0]   status;
		logic [BCELC_DATA_W-1:0]     data;
		logic [BCELC_PTR_W-1:0]      txPtr;
		logic [BCELC_PTR_W-1:0]      rxPtr;
	} bcelc_chan_s;

	bcelc_chan_s stateReg;
	bcelc_chan_s stateNext;

	function automatic bcelc_chan_s bcelc_cleared(input bcelc_chan_s s);
		bcelc_chan_s c;
		c        = s;
		c.busy   = 1'b0;
		c.clr    = 1'b1;
		c.status = BCELC_STATUS_RST;
		c.data   = BCELC_DATA_RST;
		c.txPtr  = BCELC_PTR_RST;
		c.rxPtr  = BCELC_PTR_RST;
		return c;
	endfunction

	logic loopRise;
	logic loopFall;
	logic disableNow;

	always_comb begin
		loopRise   = loopRequest && !stateReg.loop;
		loopFall   = !loopRequest && stateReg.loop;
		disableNow = enableClear && (stateReg.mode == BCELC_NORMAL);
		stateNext     = stateReg;
		stateNext.clr = 1'b0;
		case (stateReg.mode)
			BCELC_OFF, BCELC_NORMAL: begin
				if (enableSet && !loopRequest && stateReg.mode == BCELC_OFF)
					stateNext.mode = BCELC_NORMAL;
			end
			BCELC_LOOP: begin
			end
			default: stateNext.mode = BCELC_OFF;
		endcase
		// pointers advance the same way in loop and normal mode
		if (stateReg.mode != BCELC_OFF) begin
			if (queuePush)
				stateNext.txPtr = stateReg.txPtr + 2'h1; // R8
			if (queuePop)
				stateNext.rxPtr = stateReg.rxPtr + 2'h1; // R8
			if (txStart)
				stateNext.busy = 1'b1;
			else if (txDone)
				stateNext.busy = 1'b0;
			stateNext.status = stateReg.status | statusSet;
			if (bufferLoad)
				stateNext.data = bufferWrite;
		end
		stateNext.txLevel = txBit;
		// loop feeds the transmitter back; the wire is ignored
		stateNext.rxLevel = stateReg.loop ? stateReg.txLevel : busRxSync; // R4 R5
		if (disableNow) begin
			stateNext      = bcelc_cleared(stateNext); // R2 R3
			stateNext.mode = BCELC_OFF; // R1
		end
		if (loopRise) begin
			stateNext      = bcelc_cleared(stateNext); // R6
			stateNext.mode = BCELC_LOOP;
			stateNext.loop = 1'b1;
		end else if (loopFall) begin
			// registers back to reset values, enable left cleared
			stateNext      = bcelc_cleared(stateNext); // R7
			stateNext.mode = BCELC_OFF;
			stateNext.loop = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			stateReg.mode    <= BCELC_OFF; // R9
			stateReg.loop    <= 1'b0;
			stateReg.busy    <= 1'b0;
			stateReg.txLevel <= 1'b0;
			stateReg.rxLevel <= 1'b0;
			stateReg.clr     <= 1'b0;
			stateReg.status  <= BCELC_STATUS_RST;
			stateReg.data    <= BCELC_DATA_RST;
			stateReg.txPtr   <= BCELC_PTR_RST;
			stateReg.rxPtr   <= BCELC_PTR_RST;
		end else begin
			stateReg <= stateNext;
		end
	end

	// driver only live in normal mode; loop cuts the wire off
	assign busTxOe       = (stateReg.mode == BCELC_NORMAL); // R1 R5
	assign busTxOut      = stateReg.txLevel & busTxOe;
	assign channelEnable = (stateReg.mode == BCELC_NORMAL);
	assign loopActive    = stateReg.loop;
	assign transferBusy  = stateReg.busy;
	assign rxBit         = stateReg.rxLevel;
	assign clearPulse    = stateReg.clr;
	assign channelStatus = stateReg.status;
	assign bufferData    = stateReg.data;
	assign txPtr         = stateReg.txPtr;
	assign rxPtr         = stateReg.rxPtr;

	chk_disable_tristate: assert property (@(posedge clock) disable iff (rst) // R1
		disableNow |=> !busTxOe && !transferBusy) else $error("driver still on after disable");
	chk_disable_clear: assert property (@(posedge clock) disable iff (rst) // R2
		disableNow |=> clearPulse && txPtr == BCELC_PTR_RST && rxPtr == BCELC_PTR_RST
			&& bufferData == BCELC_DATA_RST && channelStatus == BCELC_STATUS_RST)
		else $error("disable did not clear channel");

	sequence seqLoopEnter;
		!loopActive ##1 loopActive;
	endsequence
	chk_loop_enter: assert property (@(posedge clock) disable iff (rst) // R6
		seqLoopEnter |-> !channelEnable && channelStatus == 8'h00 && txPtr == 2'h0)
		else $error("loop entry did not clear channel");
	chk_loop_exit: assert property (@(posedge clock) disable iff (rst) // R7
		$fell(loopActive) |-> !channelEnable && rxPtr == 2'h0 && !transferBusy)
		else $error("loop exit did not reset channel");
	chk_loop_route: assert property (@(posedge clock) disable iff (rst) // R4
		loopActive && $past(loopActive) |=> rxBit == $past(txBit, 2)) else $error("loop path broken");
	chk_loop_nodrive: assert property (@(posedge clock) disable iff (rst) // R5
		loopActive |-> !busTxOe) else $error("bus driven in loop");
	chk_loop_pointer: assert property (@(posedge clock) disable iff (rst) // R8
		loopActive && queuePush && !loopFall |=> txPtr == $past(txPtr) + 2'h1) else $error("pointer stuck");
	chk_reset_off: assert property (@(posedge clock) // R9
		rst |=> !channelEnable && !busTxOe) else $error("reset left channel on");

endmodule // bcelc_channel

// [logic/bcelc_pkg.sv]
// package: constants and types for the channel enable and loop control block
package bcelc_pkg;

	localparam int          BCELC_CHANNELS     = 4;
	localparam int          BCELC_QUEUE_DEPTH  = 4;
	localparam int          BCELC_PTR_W        = 2;
	localparam int          BCELC_STATUS_W     = 8;
	localparam int          BCELC_DATA_W       = 16;
	localparam logic        BCELC_ENABLE_RST   = 1'b0;
	localparam logic [7:0]  BCELC_STATUS_RST   = 8'h00;
	localparam logic [15:0] BCELC_DATA_RST     = 16'h0000;
	localparam logic [1:0]  BCELC_PTR_RST      = 2'h0;

	typedef enum {
		BCELC_OFF,
		BCELC_NORMAL,
		BCELC_LOOP
	} bcelc_mode_e;

endpackage

// [logic/bcelc_top.sv]
// top: four independent channels with synchronised bus receive pins
`timescale 1ns/1ps
// Summary of operation
// R1: a disabled channel releases its bus driver to high impedance.
// R2: disabling clears the channel buffer data, status bits and both queue pointers.
// R3: a transfer under way when the channel is disabled ends at once.
// R4: in loop mode the transmit path feeds the receive path inside the device.
// R5: in loop mode the external bus is cut from both transmitter and receiver.
// R6: entering loop mode clears the enable, buffer, status and queues.
// R7: leaving loop mode returns the channel to reset values and resets the queues.
// R8: queue pointers advance in loop mode exactly as in normal mode.
// R9: device reset clears all state and leaves every channel disabled and tri-stated.
// R10: each channel has its own enable and loop control, independent of the others.
// R11: the host must set the enable again after loop, reset or disable before the bus is driven.
module bcelc_top
	import bcelc_pkg::*;
(
	// clock and reset
	input  wire logic                                       clock,
	input  wire logic                                       rst,
	// per-channel control
	input  wire logic [BCELC_CHANNELS-1:0]                  enableSet,
	input  wire logic [BCELC_CHANNELS-1:0]                  enableClear,
	input  wire logic [BCELC_CHANNELS-1:0]                  loopRequest,
	// per-channel transfer side
	input  wire logic [BCELC_CHANNELS-1:0]                  txStart,
	input  wire logic [BCELC_CHANNELS-1:0]                  txBit,
	input  wire logic [BCELC_CHANNELS-1:0]                  txDone,
	input  wire logic [BCELC_CHANNELS-1:0]                  queuePush,
	input  wire logic [BCELC_CHANNELS-1:0]                  queuePop,
	input  wire logic [BCELC_CHANNELS*BCELC_STATUS_W-1:0]   statusSet,
	input  wire logic [BCELC_CHANNELS*BCELC_DATA_W-1:0]     bufferWrite,
	input  wire logic [BCELC_CHANNELS-1:0]                  bufferLoad,
	// bus pins
	input  wire logic [BCELC_CHANNELS-1:0]                  busRxPin,
	output logic [BCELC_CHANNELS-1:0]                       busTxOut,
	output logic [BCELC_CHANNELS-1:0]                       busTxOe,
	// observed state
	output logic [BCELC_CHANNELS-1:0]                       channelEnable,
	output logic [BCELC_CHANNELS-1:0]                       loopActive,
	output logic [BCELC_CHANNELS-1:0]                       transferBusy,
	output logic [BCELC_CHANNELS-1:0]                       rxBit,
	output logic [BCELC_CHANNELS-1:0]                       clearPulse,
	output logic [BCELC_CHANNELS*BCELC_STATUS_W-1:0]        channelStatus,
	output logic [BCELC_CHANNELS*BCELC_DATA_W-1:0]          bufferData,
	output logic [BCELC_CHANNELS*BCELC_PTR_W-1:0]           txPtr,
	output logic [BCELC_CHANNELS*BCELC_PTR_W-1:0]           rxPtr
);

	typedef struct packed {
		logic [BCELC_CHANNELS-1:0] meta;
		logic [BCELC_CHANNELS-1:0] sync;
	} bcelc_sync_s;

	bcelc_sync_s syncReg;
	bcelc_sync_s syncNext;

	// two stages: the pin comes from the asynchronous bus
	always_comb begin
		syncNext      = syncReg;
		syncNext.meta = busRxPin;
		syncNext.sync = syncReg.meta;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			syncReg <= '0;
		end else begin
			syncReg <= syncNext;
		end
	end

	// each channel is its own instance, so no control crosses channels
	genvar ch;
	generate
		for (ch = 0; ch < BCELC_CHANNELS; ch++) begin : gChan // R10
			bcelc_channel uChannel (
				.clock         (clock),
				.rst           (rst),
				.enableSet     (enableSet[ch]),
				.enableClear   (enableClear[ch]),
				.loopRequest   (loopRequest[ch]),
				.txStart       (txStart[ch]),
				.txBit         (txBit[ch]),
				.txDone        (txDone[ch]),
				.queuePush     (queuePush[ch]),
				.queuePop      (queuePop[ch]),
				.statusSet     (statusSet[ch*BCELC_STATUS_W +: BCELC_STATUS_W]),
				.bufferWrite   (bufferWrite[ch*BCELC_DATA_W +: BCELC_DATA_W]),
				.bufferLoad    (bufferLoad[ch]),
				.busRxSync     (syncReg.sync[ch]),
				.busTxOut      (busTxOut[ch]),
				.busTxOe       (busTxOe[ch]),
				.channelEnable (channelEnable[ch]),
				.loopActive    (loopActive[ch]),
				.transferBusy  (transferBusy[ch]),
				.rxBit         (rxBit[ch]),
				.clearPulse    (clearPulse[ch]),
				.channelStatus (channelStatus[ch*BCELC_STATUS_W +: BCELC_STATUS_W]),
				.bufferData    (bufferData[ch*BCELC_DATA_W +: BCELC_DATA_W]),
				.txPtr         (txPtr[ch*BCELC_PTR_W +: BCELC_PTR_W]),
				.rxPtr         (rxPtr[ch*BCELC_PTR_W +: BCELC_PTR_W])
			);

			chk_disable_isolated: assert property (@(posedge clock) disable iff (rst) // R10
				enableClear[ch] && channelEnable[ch] && !loopRequest[ch] && !enableSet[(ch+1)%BCELC_CHANNELS]
				&& !loopRequest[(ch+1)%BCELC_CHANNELS] && !enableClear[(ch+1)%BCELC_CHANNELS]
				|=> $stable(channelEnable[(ch+1)%BCELC_CHANNELS]))
				else $error("neighbour channel disturbed");
			chk_reenable_needed: assert property (@(posedge clock) disable iff (rst) // R11
				$rose(channelEnable[ch]) |-> $past(enableSet[ch])) else $error("enabled without request");
			chk_stop_transfer: assert property (@(posedge clock) disable iff (rst) // R3
				enableClear[ch] && channelEnable[ch] |=> !transferBusy[ch] ##1 (!busTxOe[ch] || $past(enableSet[ch])))
				else $error("transfer not stopped");
		end
	endgenerate

endmodule // bcelc_top

// [verification/bcelc_slave_node.sv]
// partner model: remote slave nodes answering on the receive pin of each channel
`timescale 1ns/1ps
module bcelc_slave_node
	import bcelc_pkg::*;
(
	// clock
	input  wire logic                      clock,
	// bus from the master
	input  wire logic [BCELC_CHANNELS-1:0] busTxOut,
	input  wire logic [BCELC_CHANNELS-1:0] busTxOe,
	// answer to the master
	output logic      [BCELC_CHANNELS-1:0] busRxPin
);
	logic [BCELC_CHANNELS-1:0] idleToggle;

	initial idleToggle = '0;
	// a released line floats: toggle it so a stale level never passes for data
	always @(posedge clock) begin
		idleToggle <= ~idleToggle;
	end
	// driven line: the node answers with the inverse of what it hears
	assign busRxPin = (busTxOe & ~busTxOut) | (~busTxOe & idleToggle);
endmodule // bcelc_slave_node

// [verification/tb_bus_channel_enable_loop_control.sv]
// testbench: reset, disable, loop mode and channel independence of the control block
`timescale 1ns/1ps
module tb_bus_channel_enable_loop_control
	import bcelc_pkg::*;
;
	logic        clock, rst;
	logic [3:0]  enableSet, enableClear, loopRequest, txStart, txBit, txDone, queuePush, queuePop, bufferLoad;
	logic [3:0]  busRxPin, busTxOut, busTxOe, channelEnable, loopActive, transferBusy, rxBit, clearPulse;
	logic [31:0] statusSet, channelStatus;
	logic [63:0] bufferWrite, bufferData;
	logic [7:0]  txPtr, rxPtr;
	logic        hist [0:7];
	int          miscompares = 0;
	int          nCompared = 0;

	bcelc_top u_dut (.clock(clock), .rst(rst), .enableSet(enableSet), .enableClear(enableClear),
		.loopRequest(loopRequest), .txStart(txStart), .txBit(txBit), .txDone(txDone), .queuePush(queuePush),
		.queuePop(queuePop), .statusSet(statusSet), .bufferWrite(bufferWrite), .bufferLoad(bufferLoad),
		.busRxPin(busRxPin), .busTxOut(busTxOut), .busTxOe(busTxOe), .channelEnable(channelEnable),
		.loopActive(loopActive), .transferBusy(transferBusy), .rxBit(rxBit), .clearPulse(clearPulse),
		.channelStatus(channelStatus), .bufferData(bufferData), .txPtr(txPtr), .rxPtr(rxPtr));
	bcelc_slave_node u_node (.clock(clock), .busTxOut(busTxOut), .busTxOe(busTxOe), .busRxPin(busRxPin));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		nCompared++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// pulse inputs return low; called right after a rising edge
	task automatic idle();
		{enableSet, enableClear, txStart, txDone, queuePush, queuePop, bufferLoad} <= '0;
		statusSet <= '0;
	endtask

	task automatic results();
		$display("compared %0d, mismatches %0d", nCompared, miscompares);
		if (miscompares == 0 && nCompared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic test_reset();
		@(posedge clock) enableSet <= 4'hF;
		@(posedge clock) enableSet <= 4'h0;
		queuePush <= 4'hF;
		@(posedge clock) rst <= 1'b1;
		queuePush <= 4'h0;
		@(posedge clock) rst <= 1'b0;
		#1 check({channelEnable, busTxOe, loopActive, transferBusy}, 0);
		check({txPtr, rxPtr}, 0);
		$display("test reset done");
	endtask

	task automatic test_disable();
		@(posedge clock) enableSet <= 4'h1;
		txBit <= 4'h1;
		@(posedge clock) enableSet <= 4'h0;
		{txStart, queuePush, queuePop, bufferLoad} <= {4{4'h1}};
		bufferWrite <= 64'hA5C3;
		statusSet <= 32'h81;
		@(posedge clock) idle();
		repeat (6) @(posedge clock);
		#1 check({transferBusy, txPtr, rxPtr}, {4'h1, 8'h01, 8'h01});
		check(bufferData, 64'hA5C3);
		check(channelStatus, 32'h81);
		check(rxBit[0], 1'b0);
		check({busTxOe, busTxOut}, 8'h11);
		@(posedge clock) enableClear <= 4'h1;
		queuePush <= 4'h1;
		@(posedge clock) idle();
		txBit <= 4'h0;
		#1 check({busTxOe, busTxOut, channelEnable}, 0);
		check(transferBusy, 0);
		check({txPtr, rxPtr, channelStatus}, 0);
		check(bufferData, 0);
		check(clearPulse, 4'h1);
		$display("test disable done");
	endtask

	task automatic test_loop();
		logic [7:0] txPattern = 8'hB2;
		@(posedge clock) enableSet <= 4'h6;
		@(posedge clock) enableSet <= 4'h0;
		bufferLoad <= 4'h2;
		bufferWrite <= 64'h1234_0000;
		@(posedge clock) idle();
		loopRequest <= 4'h2;
		@(posedge clock);
		#1 check({loopActive, channelEnable, clearPulse}, {4'h2, 4'h4, 4'h2});
		check(bufferData, 0);
		check({txPtr, channelStatus}, 0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) hist[i] = txBit[1];
			txBit[1] <= txPattern[i];
			queuePush[1] <= (i < 3);
			enableSet[1] <= (i == 4);
			#1 check({busTxOe, busTxOut}, 8'h40);
			if (i > 0) check(rxBit[1], hist[i-1]);
		end
		@(posedge clock) idle();
		#1 check({txPtr[3:2], channelEnable}, {2'h3, 4'h4});
		@(posedge clock) loopRequest <= 4'h0;
		@(posedge clock);
		#1 check({loopActive, clearPulse[1], txPtr, channelEnable}, {4'h0, 1'b1, 8'h00, 4'h4});
		@(posedge clock) enableSet <= 4'h2;
		@(posedge clock) idle();
		#1 check(busTxOe, 4'h6);
		@(posedge clock) txStart <= 4'h2;
		@(posedge clock) txStart <= 4'h0;
		txDone <= 4'h2;
		#1 check(transferBusy, 4'h2);
		@(posedge clock) txDone <= 4'h0;
		#1 check(transferBusy, 4'h0);
		$display("test loop done");
	endtask

	initial begin
		rst = 1'b1;
		{enableSet, enableClear, loopRequest, txStart, txBit, txDone, queuePush, queuePop, bufferLoad} = '0;
		statusSet = '0;
		bufferWrite = '0;
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		#1 check({channelEnable, busTxOe, txPtr, rxPtr, channelStatus}, 0);
		test_reset();
		test_disable();
		test_loop();
		results();
	end

	// hang guard: the tests need well under 200 cycles
	initial begin
		repeat (2000) @(posedge clock);
		miscompares++;
		results();
	end
endmodule // tb_bus_channel_enable_loop_control
